// File: verilog/pmc_misc_config_regs.sv
/*
  Configuration command registers of the converter: option word, pin-strap
  override word and bus address byte, plus the load sequence after power-on
  reset and on restore, and the control outputs driven by the option bits.
  Assumes an outside protocol engine presenting decoded commands (code, data,
  write/read strobes, PEC presence), a backup store that supplies the saved
  words, and pin-strap values sampled from pins (synchronised here).
*/
`timescale 1ns/1ps
`default_nettype none

module pmc_misc_config_regs #(
  parameter int OVR_GROUPS = pmc_pkg::PMC_OVR_GROUPS
) (
  // Clock, reset, enable
  input  wire logic                               clock,
  input  wire logic                               rst_n,
  input  wire logic                               clk_en,
  // Decoded command port from the protocol engine
  input  wire logic [7:0]                         cmd_code,
  input  wire logic [15:0]                        cmd_wdata,
  input  wire logic                               cmd_write,
  input  wire logic                               cmd_read,
  input  wire logic                               cmd_pec_present,
  output logic [15:0]                             cmd_rdata,
  output logic                                    cmd_accept,
  output logic                                    cmd_pec_error,
  output logic                                    cmd_invalid_data,
  // Backup store contents
  input  wire logic                               nvm_valid,
  input  wire logic [15:0]                        nvm_misc,
  input  wire logic [15:0]                        nvm_override,
  input  wire logic [pmc_pkg::PMC_ADDR_W-1:0]     nvm_address,
  input  wire logic                               restore_req,
  // Pin straps (asynchronous)
  input  wire logic [pmc_pkg::PMC_ADDR_W-1:0]     strap_address,
  // Converter events
  input  wire logic                               shutdown_event,
  input  wire logic                               fault_restart_event,
  input  wire logic                               retry_enabled,
  // Configuration outputs
  output logic [pmc_pkg::PMC_ADDR_W-1:0]          bus_address,
  output logic                                    load_done,
  output logic                                    reload_setpoint,
  output logic                                    reset_pin_mode,
  output logic                                    pin_pullup_en,
  output logic                                    fault_counter_policy,
  output logic [4:0]                              telemetry_bits,
  output logic [OVR_GROUPS-1:0]                   group_use_pin,
  output logic                                    group_load
);
  import pmc_pkg::*;

  // Elaboration check: group outputs map one to one onto override bits
  if (OVR_GROUPS != PMC_OVR_GROUPS) begin : g_bad_groups
    $error("OVR_GROUPS must match the override word layout");
  end

  // ****************************************************************
  // Load sequencer
  // ****************************************************************
  typedef enum logic [1:0] {
    PMC_ST_WAIT_NVM,
    PMC_ST_SUBST,
    PMC_ST_RUN,
    PMC_ST_RESTORE
  } pmc_state_e;

  pmc_state_e state;
  pmc_state_e next_state;

  logic [15:0]              misc_options_word;
  logic [15:0]              pin_strap_priority_word;
  logic [PMC_ADDR_W-1:0]    bus_address_byte;
  logic [PMC_ADDR_W-1:0]    strap_meta;
  logic [PMC_ADDR_W-1:0]    strap_sync;
  logic [PMC_ADDR_W-1:0]    strap_latched;
  logic                     addr_reserved;
  logic                     wr_ok;
  logic                     bad_data;

  // Two-stage synchroniser for strap pins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strap_meta <= '0;
      strap_sync <= '0;
    end else if (clk_en) begin
      strap_meta <= strap_address;
      strap_sync <= strap_meta;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      PMC_ST_WAIT_NVM: if (nvm_valid) next_state = PMC_ST_SUBST;
      PMC_ST_SUBST:    next_state = PMC_ST_RUN;
      PMC_ST_RUN:      if (restore_req) next_state = PMC_ST_RESTORE;
      PMC_ST_RESTORE:  next_state = PMC_ST_SUBST;
      default:         next_state = PMC_ST_WAIT_NVM;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= PMC_ST_WAIT_NVM;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strap_latched <= '0;
    end else if (clk_en && state == PMC_ST_WAIT_NVM && nvm_valid) begin
      strap_latched <= strap_sync;
    end
  end

  assign load_done = (state == PMC_ST_RUN);

  // ****************************************************************
  // Command decode
  // ****************************************************************
  pmc_addr_check i_pmc_addr_check (
    .addr        (cmd_wdata[PMC_ADDR_W-1:0]),
    .is_reserved (addr_reserved)
  );

  assign cmd_pec_error = cmd_write && load_done && misc_options_word[PMC_MISC_PEC_REQ]
                         && !cmd_pec_present;

  always_comb begin
    bad_data = 1'b0;
    if (cmd_code == PMC_CMD_ADDRESS) begin
      bad_data = addr_reserved;
    end else if (cmd_code == PMC_CMD_OVERRIDE) begin
      bad_data = 1'b0;
    end
  end

  assign wr_ok = cmd_write && load_done && !cmd_pec_error && !bad_data;
  assign cmd_invalid_data = cmd_write && load_done && !cmd_pec_error && bad_data;
  assign cmd_accept = wr_ok;

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Option word, live update
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      misc_options_word <= '0;
    end else if (clk_en) begin
      if (state == PMC_ST_WAIT_NVM && nvm_valid) begin
        misc_options_word <= nvm_misc;
      end else if (wr_ok && cmd_code == PMC_CMD_MISC) begin
        misc_options_word <= cmd_wdata & PMC_MISC_MASK;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_strap_priority_word <= '0;
    end else if (clk_en) begin
      if (state == PMC_ST_WAIT_NVM && nvm_valid) begin
        pin_strap_priority_word <= nvm_override;
      end else if (wr_ok && cmd_code == PMC_CMD_OVERRIDE) begin
        pin_strap_priority_word <= cmd_wdata & ~PMC_OVR_RSVD_MASK;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus_address_byte <= '0;
    end else if (clk_en) begin
      if (state == PMC_ST_WAIT_NVM && nvm_valid) begin
        bus_address_byte <= nvm_address;
      end else if (state == PMC_ST_RESTORE) begin
        bus_address_byte <= nvm_address;
      end else if (state == PMC_ST_SUBST && pin_strap_priority_word[PMC_OVR_ADDR]) begin
        bus_address_byte <= strap_latched;
      end else if (wr_ok && cmd_code == PMC_CMD_ADDRESS) begin
        bus_address_byte <= cmd_wdata[PMC_ADDR_W-1:0];
      end
    end
  end

  assign bus_address = bus_address_byte;

  // Read data
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmd_rdata <= '0;
    end else if (clk_en && cmd_read) begin
      if (cmd_code == PMC_CMD_MISC) begin
        cmd_rdata <= misc_options_word;
      end else if (cmd_code == PMC_CMD_OVERRIDE) begin
        cmd_rdata <= pin_strap_priority_word;
      end else if (cmd_code == PMC_CMD_ADDRESS) begin
        cmd_rdata <= {9'h000, bus_address_byte};
      end else begin
        cmd_rdata <= '0;
      end
    end
  end

  // ****************************************************************
  // Group load selection
  // ****************************************************************
  // Load strobe at power-on and restore
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      group_load    <= 1'b0;
      group_use_pin <= '0;
    end else if (clk_en) begin
      group_load <= (state == PMC_ST_SUBST);
      if (state == PMC_ST_SUBST) begin
        group_use_pin[0] <= pin_strap_priority_word[PMC_OVR_STACK];
        group_use_pin[1] <= pin_strap_priority_word[PMC_OVR_SYNC];
        group_use_pin[2] <= pin_strap_priority_word[PMC_OVR_COMP];
        group_use_pin[3] <= pin_strap_priority_word[PMC_OVR_ADDR];
        group_use_pin[4] <= pin_strap_priority_word[PMC_OVR_ILV];
        group_use_pin[5] <= pin_strap_priority_word[PMC_OVR_TON];
        group_use_pin[6] <= pin_strap_priority_word[PMC_OVR_IOC];
        group_use_pin[7] <= pin_strap_priority_word[PMC_OVR_SWITCHING_RATE_SOURCE];
        group_use_pin[8] <= pin_strap_priority_word[PMC_OVR_OUTPUT_VOLTAGE_GROUP_SOURCE];
      end
    end
  end

  // ****************************************************************
  // Option outputs
  // ****************************************************************
  // Setpoint reload pulse
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reload_setpoint <= 1'b0;
    end else if (clk_en) begin
      reload_setpoint <= (shutdown_event && misc_options_word[PMC_MISC_RLD_SHDN])
                      || (fault_restart_event && retry_enabled
                          && misc_options_word[PMC_MISC_RLD_FLT]);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reset_pin_mode <= 1'b0;
      pin_pullup_en  <= 1'b0;
    end else if (clk_en) begin
      reset_pin_mode <= misc_options_word[PMC_MISC_RST_MODE];
      pin_pullup_en  <= misc_options_word[PMC_MISC_RST_MODE]
                        && !misc_options_word[PMC_MISC_PULLUP_N];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fault_counter_policy <= 1'b0;
      telemetry_bits       <= PMC_BITS_12;
    end else if (clk_en) begin
      fault_counter_policy <= misc_options_word[PMC_MISC_FLT_POL];
      case (pmc_res_e'(misc_options_word[PMC_MISC_RES_HI:PMC_MISC_RES_LO]))
        PMC_RES_12: telemetry_bits <= PMC_BITS_12;
        PMC_RES_10: telemetry_bits <= PMC_BITS_10;
        PMC_RES_8:  telemetry_bits <= PMC_BITS_8;
        default:    telemetry_bits <= PMC_BITS_6;
      endcase
    end
  end

endmodule
`default_nettype wire

// File: verilog/pmc_pkg.sv
/*
  Package for the converter configuration command block: command codes,
  field positions, encodings and reserved bus addresses.
  Assumes a PMBus protocol engine outside that decodes frames into
  command writes and reads.
*/
package pmc_pkg;

  // ****************************************************************
  // Command codes
  // ****************************************************************
  localparam logic [7:0] PMC_CMD_MISC     = 8'hed;
  localparam logic [7:0] PMC_CMD_OVERRIDE = 8'hee;
  localparam logic [7:0] PMC_CMD_ADDRESS  = 8'hef;

  // ****************************************************************
  // Option word fields
  // ****************************************************************
  localparam int PMC_MISC_PEC_REQ   = 15;
  localparam int PMC_MISC_RLD_SHDN  = 14;
  localparam int PMC_MISC_RLD_FLT   = 13;
  localparam int PMC_MISC_RST_MODE  = 12;
  localparam int PMC_MISC_PULLUP_N  = 3;
  localparam int PMC_MISC_FLT_POL   = 2;
  localparam int PMC_MISC_RES_HI    = 1;
  localparam int PMC_MISC_RES_LO    = 0;
  // Writable bits of the option word (reserved 11:4 read as written)
  localparam logic [15:0] PMC_MISC_MASK = 16'hffff;

  // ****************************************************************
  // Override word fields
  // ****************************************************************
  localparam int PMC_OVR_STACK = 12;
  localparam int PMC_OVR_SYNC  = 11;
  localparam int PMC_OVR_COMP  = 9;
  localparam int PMC_OVR_ADDR  = 8;
  localparam int PMC_OVR_ILV   = 5;
  localparam int PMC_OVR_TON   = 3;
  localparam int PMC_OVR_IOC   = 2;
  localparam int PMC_OVR_SWITCHING_RATE_SOURCE  = 1;
  localparam int PMC_OVR_OUTPUT_VOLTAGE_GROUP_SOURCE  = 0;
  localparam int PMC_OVR_GROUPS = 9;
  localparam logic [15:0] PMC_OVR_RSVD_MASK = 16'he000;

  // ****************************************************************
  // Address byte
  // ****************************************************************
  localparam int PMC_ADDR_W = 7;
  localparam int PMC_NUM_RSVD_ADDR = 4;
  localparam logic [6:0] PMC_RSVD_ADDR [PMC_NUM_RSVD_ADDR] =
    '{7'h0c, 7'h28, 7'h37, 7'h61};

  // ****************************************************************
  // Telemetry resolution encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    PMC_RES_12 = 2'h0,
    PMC_RES_10 = 2'h1,
    PMC_RES_8  = 2'h2,
    PMC_RES_6  = 2'h3
  } pmc_res_e;
  localparam logic [4:0] PMC_BITS_12 = 5'h0c;
  localparam logic [4:0] PMC_BITS_10 = 5'h0a;
  localparam logic [4:0] PMC_BITS_8  = 5'h08;
  localparam logic [4:0] PMC_BITS_6  = 5'h06;

endpackage

// File: verilog/pmc_addr_check.sv
/*
  Checks a proposed bus address against the reserved SMBus addresses.
  Purely combinational; used by the command block on address writes.
*/
`timescale 1ns/1ps
`default_nettype none

module pmc_addr_check (
  // Address under test
  input  wire logic [pmc_pkg::PMC_ADDR_W-1:0] addr,
  // Result
  output logic                               is_reserved
);
  import pmc_pkg::*;

  logic [PMC_NUM_RSVD_ADDR-1:0] hit;

  genvar g;
  generate
    for (g = 0; g < PMC_NUM_RSVD_ADDR; g++) begin : g_cmp
      assign hit[g] = (addr == PMC_RSVD_ADDR[g]);
    end
  endgenerate

  assign is_reserved = |hit;

endmodule
`default_nettype wire

// File: sim/pmc_misc_config_regs_props.sv
/*
  Concurrent checks on the ports of the configuration command block.
  Assumes it is bound onto pmc_misc_config_regs and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module pmc_misc_config_regs_chk (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        clk_en,
  // Command port
  input wire logic [7:0]  cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic        cmd_write,
  input wire logic        cmd_read,
  input wire logic        cmd_pec_present,
  input wire logic [15:0] cmd_rdata,
  input wire logic        cmd_accept,
  input wire logic        cmd_pec_error,
  input wire logic        cmd_invalid_data,
  // Events and outputs
  input wire logic        shutdown_event,
  input wire logic        fault_restart_event,
  input wire logic [6:0]  bus_address,
  input wire logic        load_done,
  input wire logic        reload_setpoint,
  input wire logic        reset_pin_mode,
  input wire logic        pin_pullup_en,
  input wire logic        fault_counter_policy,
  input wire logic [4:0]  telemetry_bits,
  input wire logic        group_load
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  logic rsv;
  logic wr_ed;
  assign rsv = cmd_wdata[6:0] inside {7'h0c, 7'h28, 7'h37, 7'h61};
  assign wr_ed = clk_en && cmd_accept && cmd_code == 8'hed;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_pec_optional: assert property (cmd_write && cmd_pec_present |-> !cmd_pec_error)
    else $error("pec error raised with pec present");
  a_reserved_addr: assert property (load_done && clk_en && cmd_write && cmd_pec_present
    && cmd_code == 8'hef && rsv |-> cmd_invalid_data && !cmd_accept)
    else $error("reserved address not refused");
  a_addr_hold: assert property (cmd_invalid_data |=> $stable(bus_address))
    else $error("address changed on refused write");
  a_addr_live: assert property (clk_en && cmd_accept && cmd_code == 8'hef
    |=> bus_address == $past(cmd_wdata[6:0]))
    else $error("new address not live next cycle");
  a_addr_bit7: assert property (clk_en && cmd_read && cmd_code == 8'hef
    |=> cmd_rdata[15:7] == 9'h000)
    else $error("address read upper bits not zero");
  a_pin_mode: assert property (wr_ed ##1 clk_en |=> reset_pin_mode == $past(cmd_wdata[12], 2)
    && pin_pullup_en == ($past(cmd_wdata[12], 2) && !$past(cmd_wdata[3], 2)))
    else $error("pin mode or pullup wrong");
  a_pgood_pullup: assert property (!reset_pin_mode |-> !pin_pullup_en)
    else $error("pullup on in power good mode");
  a_count_policy: assert property (wr_ed ##1 clk_en |=> fault_counter_policy == $past(cmd_wdata[2], 2))
    else $error("fault counter policy wrong");
  a_res_map: assert property (wr_ed ##1 clk_en
    |=> telemetry_bits == 5'h0c - {2'h0, $past(cmd_wdata[1:0], 2), 1'b0})
    else $error("telemetry resolution wrong");
  a_reload_cause: assert property (reload_setpoint && $past(clk_en)
    |-> $past(shutdown_event || fault_restart_event))
    else $error("reload without event");
  a_accept_gate: assert property (cmd_accept |-> load_done && cmd_write
    && !cmd_pec_error && !cmd_invalid_data)
    else $error("write accepted when it must not be");
  a_load_pulse: assert property ($rose(load_done) |-> group_load)
    else $error("load done without group load");

  c_pec_err: cover property (cmd_pec_error);
  c_bad_addr: cover property (cmd_invalid_data);
  c_reload: cover property (reload_setpoint);
endmodule

bind pmc_misc_config_regs pmc_misc_config_regs_chk i_pmc_misc_config_regs_chk (.*);

`default_nettype wire

// File: sim/pmc_store_model.sv
/*
  Backup store and strap pins seen from the block.
  Assumes clock and rst_n of the block; strap value comes from the bench.
*/
`timescale 1ns/1ps
`default_nettype none

module pmc_store_model #(
  parameter logic [15:0] MISC = 16'h1006,
  parameter logic [15:0] OVR  = 16'h0925,
  parameter logic [6:0]  ADDR = 7'h10
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Strap level from the bench
  input  wire logic [6:0]  strap_in,
  // Store contents
  output logic             nvm_valid,
  output logic [15:0]      nvm_misc,
  output logic [15:0]      nvm_override,
  output logic [6:0]       nvm_address,
  output logic [6:0]       strap_address
);
  logic [2:0] cnt;

  // Contents valid after straps settle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 3'h0;
    end else if (cnt != 3'h5) begin
      cnt <= cnt + 3'h1;
    end
  end
  assign nvm_valid = cnt == 3'h5;

  assign nvm_misc = nvm_valid ? MISC : ~MISC;
  assign nvm_override = nvm_valid ? OVR : ~OVR;
  assign nvm_address = nvm_valid ? ADDR : ~ADDR;
  assign strap_address = strap_in;
endmodule

`default_nettype wire

// File: sim/test_pmc_misc_config_regs.sv
/*
  Testbench for the configuration command block.
  Assumes the store model as backup source; drives at falling edges.
*/
`timescale 1ns/1ps
`default_nettype none

module test_pmc_misc_config_regs;
  import pmc_pkg::*;
  logic clock, rst_n, clk_en, cmd_write, cmd_read, pec, restore_req;
  logic shutdown_event, fault_restart_event, retry_enabled;
  logic nvm_valid, load_done, reload_setpoint, reset_pin_mode, group_load;
  logic pin_pullup_en, fault_counter_policy, acc, pe, inv;
  logic cmd_accept, cmd_pec_error, cmd_invalid_data;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, cmd_rdata, nvm_misc, nvm_override;
  logic [6:0] nvm_address, strap_address, strap, bus_address;
  logic [4:0] telemetry_bits;
  logic [8:0] group_use_pin;
  int miscompares, n_tests, k;

  pmc_store_model i_pmc_store_model (.clock(clock), .rst_n(rst_n), .strap_in(strap),
    .nvm_valid(nvm_valid), .nvm_misc(nvm_misc), .nvm_override(nvm_override),
    .nvm_address(nvm_address), .strap_address(strap_address));

  pmc_misc_config_regs i_pmc_misc_config_regs (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_write(cmd_write), .cmd_read(cmd_read),
    .cmd_pec_present(pec), .cmd_rdata(cmd_rdata), .cmd_accept(cmd_accept),
    .cmd_pec_error(cmd_pec_error), .cmd_invalid_data(cmd_invalid_data),
    .nvm_valid(nvm_valid), .nvm_misc(nvm_misc), .nvm_override(nvm_override),
    .nvm_address(nvm_address), .restore_req(restore_req), .strap_address(strap_address),
    .shutdown_event(shutdown_event), .fault_restart_event(fault_restart_event),
    .retry_enabled(retry_enabled), .bus_address(bus_address), .load_done(load_done),
    .reload_setpoint(reload_setpoint), .reset_pin_mode(reset_pin_mode),
    .pin_pullup_en(pin_pullup_en), .fault_counter_policy(fault_counter_policy),
    .telemetry_bits(telemetry_bits), .group_use_pin(group_use_pin), .group_load(group_load));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic p);
    @(negedge clock);
    cmd_code = c;
    cmd_wdata = d;
    pec = p;
    cmd_write = 1'b1;
    #1;
    acc = cmd_accept;
    pe = cmd_pec_error;
    inv = cmd_invalid_data;
    @(negedge clock);
    cmd_write = 1'b0;
    // Option outputs are registered one cycle after the word itself
    @(negedge clock);
  endtask

  task automatic rd(input logic [7:0] c, input logic [15:0] exp);
    @(negedge clock);
    cmd_code = c;
    cmd_read = 1'b1;
    @(negedge clock);
    cmd_read = 1'b0;
    chk("rdata", cmd_rdata, exp);
  endtask

  task automatic ev(input logic s, input logic f, input logic r, input logic exp);
    @(negedge clock);
    shutdown_event = s;
    fault_restart_event = f;
    retry_enabled = r;
    @(negedge clock);
    shutdown_event = 1'b0;
    fault_restart_event = 1'b0;
    chk("reload", reload_setpoint, exp);
  endtask

  task automatic wait_for(input logic which);
    for (k = 0; k < 40 && !(which ? load_done : group_load); k++) @(negedge clock);
    if (!(which ? load_done : group_load)) begin
      miscompares++;
      give_verdict();
    end
  endtask

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {rst_n, cmd_write, cmd_read, pec, restore_req, shutdown_event} = 6'h0;
    {fault_restart_event, retry_enabled, cmd_code, cmd_wdata} = 26'h0;
    strap = 7'h2a;
    clk_en = 1'b1;
    miscompares = 0;
    n_tests = 0;
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    wait_for(1'b1);
    chk("address", bus_address, 16'h002a);
    chk("groups", group_use_pin, 16'h015a);
    chk("policy", fault_counter_policy, 16'h0001);
    chk("pullup", pin_pullup_en, 16'h0001);
    rd(8'hed, 16'h1006);
    rd(8'hee, 16'h0925);
    $display("power-on load done");
    for (int i = 0; i < 4; i++) begin
      wr(8'hed, 16'(i), 1'b0);
      chk("bits", telemetry_bits, 16'(12 - 2 * i));
      chk("pullup", pin_pullup_en, 16'h0000);
    end
    wr(8'hed, 16'h1008, 1'b0);
    chk("mode", reset_pin_mode, 16'h0001);
    chk("pullup", pin_pullup_en, 16'h0000);
    // Write while the clock enable is low must not land
    clk_en = 1'b0;
    wr(8'hed, 16'h0003, 1'b0);
    clk_en = 1'b1;
    rd(8'hed, 16'h1008);
    chk("freeze", telemetry_bits, 16'h000c);
    $display("option fields done");
    wr(8'hed, 16'hc000, 1'b1);
    wr(8'hed, 16'h0000, 1'b0);
    chk("pec_err", {acc, pe}, 16'h0001);
    wr(8'hed, 16'h4000, 1'b1);
    chk("accept", acc, 16'h0001);
    rd(8'hed, 16'h4000);
    $display("packet check done");
    ev(1'b1, 1'b0, 1'b0, 1'b1);
    ev(1'b0, 1'b1, 1'b1, 1'b0);
    wr(8'hed, 16'h2000, 1'b0);
    ev(1'b1, 1'b0, 1'b0, 1'b0);
    ev(1'b0, 1'b1, 1'b1, 1'b1);
    ev(1'b0, 1'b1, 1'b0, 1'b0);
    $display("setpoint reload done");
    wr(8'hef, 16'h0033, 1'b0);
    chk("address", bus_address, 16'h0033);
    for (int i = 0; i < PMC_NUM_RSVD_ADDR; i++) begin
      wr(8'hef, 16'(PMC_RSVD_ADDR[i]), 1'b0);
      chk("refuse", {inv, acc, bus_address}, 16'h0133);
    end
    wr(8'hef, 16'h00c5, 1'b0);
    rd(8'hef, 16'h0045);
    $display("address done");
    // Host keeps reserved override bits zero
    wr(8'hee, 16'h0001, 1'b0);
    strap = 7'h55;
    @(negedge clock);
    restore_req = 1'b1;
    @(negedge clock);
    restore_req = 1'b0;
    wait_for(1'b0);
    chk("groups", group_use_pin, 16'h0100);
    chk("address", bus_address, 16'h0010);
    wr(8'hee, 16'h0100, 1'b0);
    @(negedge clock);
    restore_req = 1'b1;
    @(negedge clock);
    restore_req = 1'b0;
    wait_for(1'b0);
    chk("address", bus_address, 16'h002a);
    rd(8'hee, 16'h0100);
    $display("restore done");
    give_verdict();
  end
endmodule

`default_nettype wire
